/* File: bench/drive_sync_cycle_scheduler_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_sync_cycle_scheduler_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} dss_row_t;
    localparam logic [7:0] AL = dss_pkg::OFS_ALIAS, DS = dss_pkg::OFS_DSEL, MS = dss_pkg::OFS_MSEL;
    localparam logic [7:0] CT = dss_pkg::OFS_CTRL, ST = dss_pkg::OFS_STAT;
    logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, syncOn = 1'b0, stall = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cmdIn, fbIn, fbData, cmdLatched, r, f, c;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] ivlTicks = 8'h03;
    logic hreadyout, hresp, syncIn, fbReady, fbValid, loopStart, profileStart, posRun, interpStep, posConvert;
    logic loopWindow, pdoWindow, driveSyncMaster, moduleSyncMaster;
    logic [15:0] paramZeroValue;
    int badCount = 0, checkCount = 0, cyc = 0, n, cnt[7];
    // Register rows: reads of reset values, then writes each followed by a read with the value expected back
    localparam dss_row_t ROWS[15] = '{'{1'b0, AL, 32'h0}, '{1'b0, DS, 32'h1}, '{1'b0, MS, 32'h1},
        '{1'b1, AL, 32'h7fff}, '{1'b0, AL, 32'h7fff}, '{1'b1, AL, 32'h8000}, '{1'b0, AL, 32'h7fff},
        '{1'b1, DS, 32'h3}, '{1'b0, DS, 32'h1}, '{1'b1, DS, 32'h2}, '{1'b0, DS, 32'h2},
        '{1'b1, MS, 32'h0}, '{1'b0, MS, 32'h0}, '{1'b1, 8'h20, 32'h1}, '{1'b0, 8'h20, 32'h0}};

    dss_sync_scheduler #(.TICK_CYCLES(20), .WIN_CYCLES(7)) uut (.sys_clk, .nrst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .syncIn, .cmdIn, .fbIn,
        .fbReady, .fbValid, .fbData, .loopStart, .profileStart, .posRun, .interpStep, .posConvert, .loopWindow,
        .pdoWindow, .cmdLatched, .driveSyncMaster, .moduleSyncMaster, .paramZeroValue);
    dss_far_model #(.TICK_CYCLES(20)) far (.sys_clk, .nrst, .syncOn, .ivlTicks, .stall, .syncIn, .fbReady,
        .fbIn, .cmdIn);

    // ***********************************
    // Clock, timeout and shared tasks
    // ***********************************
    always #4 sys_clk = ~sys_clk;
    // Whole run needs about 3100 cycles; a hang ends here
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            badCount++;
            testDone();
        end
    end
    task automatic testDone;
        $display("checks=%0d mismatches=%0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single word transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin
            @(posedge sys_clk);
            k = k + 1;
        end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge sys_clk);
            k = k + 1;
        end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
    endtask
    // Edge that ends a profile cycle; grabs the far side's values there
    task automatic waitProf(output logic [31:0] fv, output logic [31:0] cv);
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k = k + 1;
        end while (profileStart !== 1'b1 && k < 3000);
        fv = fbIn;
        cv = cmdIn;
    endtask
    // Counts over one profile cycle: cycles, loops, steps, converts, windows, runs
    task automatic span(input int e0, input int e1, input int e2, input int e3, input int e4);
        cnt = '{default: 0};
        do begin
            @(posedge sys_clk);
            cnt[0] += 1;
            cnt[1] += loopStart;
            cnt[2] += interpStep;
            cnt[3] += posConvert;
            cnt[4] += loopWindow;
            cnt[5] += pdoWindow;
            cnt[6] += posRun;
        end while (profileStart !== 1'b1 && cnt[0] < 3000);
        chk(cnt[0], e0);
        chk(cnt[1], e1);
        chk(cnt[2], (e1 - 1) * e2);
        chk(cnt[3], e1 * e2);
        chk(cnt[4], e1 * 7);
        chk(cnt[5], 7);
        chk(cnt[6], 1);
        chk(cnt[0] / 20, e3 + e4);
    endtask

    // ***********************************
    // Main sequence
    // ***********************************
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        foreach (ROWS[i]) begin
            bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, r);
            if (!ROWS[i].w) chk(r, ROWS[i].d);
        end
        chk(paramZeroValue, 16'h7fff);
        chk(driveSyncMaster, 1'b1);
        chk(moduleSyncMaster, 1'b0);
        bus(1'b0, ST, 32'h0, r);
        chk(r[27:16], 12'h224);
        bus(1'b1, DS, 32'h1, r);
        bus(1'b1, MS, 32'h1, r);
        $display("test registers done");
        waitProf(f, c);
        span(20, 1, 0, 1, 0);
        $display("test free running done");
        bus(1'b1, CT, 32'h43, r);
        syncOn <= 1'b1;
        repeat (4) waitProf(f, c);
        span(60, 3, 1, 3, 0);
        bus(1'b0, ST, 32'h0, r);
        chk({r[15:8], r[0]}, 9'h007);
        chk({driveSyncMaster, moduleSyncMaster}, 2'h3);
        waitProf(f, c);
        @(posedge sys_clk);
        chk(cmdLatched, c);
        n = 0;
        while (fbValid !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            n = n + 1;
        end
        chk(fbData, f >> 4);
        ivlTicks <= 8'h3d;
        repeat (2600) @(posedge sys_clk);
        bus(1'b0, ST, 32'h0, r);
        chk(r[0], 1'b0);
        chk(driveSyncMaster, 1'b0);
        $display("test distributed clock done");
        syncOn <= 1'b0;
        bus(1'b1, CT, 32'h40, r);
        stall <= 1'b1;
        repeat (6) waitProf(f, c);
        repeat (8) @(posedge sys_clk);
        chk(fbValid, 1'b1);
        stall <= 1'b0;
        n = 0;
        repeat (4) begin
            @(posedge sys_clk);
            n += (fbValid && fbReady);
        end
        chk(n, 2);
        chk(fbValid, 1'b0);
        bus(1'b0, ST, 32'h0, r);
        chk(r[1], 1'b1);
        $display("test feedback buffer done");
        bus(1'b1, DS, 32'h2, r);
        nrst <= 1'b0;
        @(posedge sys_clk);
        chk({loopStart, driveSyncMaster, hreadyout, hresp}, 4'h2);
        nrst <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, DS, 32'h0, r);
        chk(r, 32'h1);
        bus(1'b0, AL, 32'h0, r);
        chk(r, 32'h0);
        $display("test reset done");
        testDone();
    end
endmodule // drive_sync_cycle_scheduler_tb
`default_nettype wire

/* File: bench/dss_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ***********************************
// Network master and drive core stand-in
// ***********************************
module dss_far_model #(
    parameter int TICK_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic syncOn,
    input wire logic [7:0] ivlTicks,
    input wire logic stall,
    output logic syncIn,
    output logic fbReady,
    output logic [31:0] fbIn,
    output logic [31:0] cmdIn
);
    int phase;
    // Square wave, rising edges a whole number of base ticks apart; idle low when off
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst || !syncOn) begin
            phase <= 0;
            syncIn <= 1'b0;
        end else begin
            phase <= (phase >= ivlTicks * TICK_CYCLES - 1) ? 0 : phase + 1;
            syncIn <= (phase < ivlTicks * TICK_CYCLES / 2);
        end
    end
    // Values move every cycle, so a capture in the wrong cycle shows up
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fbIn <= 32'h00000100;
            cmdIn <= 32'h00005a00;
        end else begin
            fbIn <= fbIn + 32'h00000001;
            cmdIn <= cmdIn + 32'h00000003;
        end
    end
    assign fbReady = !stall;
endmodule // dss_far_model
`default_nettype wire

/* File: core/dss_sync_scheduler.sv */
`timescale 1ns/100ps
`default_nettype none
module dss_sync_scheduler #(
    parameter int TICK_CYCLES = dss_pkg::TICK_CYC,
    parameter int WIN_CYCLES = dss_pkg::WIN_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic syncIn,
    input wire logic [31:0] cmdIn,
    input wire logic [31:0] fbIn,
    input wire logic fbReady,
    output logic fbValid,
    output logic [31:0] fbData,
    output logic loopStart,
    output logic profileStart,
    output logic posRun,
    output logic interpStep,
    output logic posConvert,
    output logic loopWindow,
    output logic pdoWindow,
    output logic [31:0] cmdLatched,
    output logic driveSyncMaster,
    output logic moduleSyncMaster,
    output logic [15:0] paramZeroValue
);
    // ***********************************
    // State
    // ***********************************
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [15:0] WIN_LEN = 16'(WIN_CYCLES);

    typedef enum logic {DSS_ACQ, DSS_LOCK} dss_lock_t;

    typedef struct packed {
        logic s1, s2, s3, lvl;
        logic [15:0] base;
        logic [7:0] since;
        logic [7:0] ivl;
        dss_lock_t lock;
        logic [15:0] loopRem;
        logic [15:0] profRem;
        logic [31:0] cmd;
        logic [31:0] fbHold;
        logic pend;
        logic late;
        logic [1:0][31:0] mem;
        logic wp, rp;
        logic [1:0] cnt;
        logic [15:0] zeroAlias;
        logic [1:0] dsel, msel;
        logic dc, interp;
        logic [3:0] shift;
        logic aAct, aWr;
        logic [7:0] aAdr;
        logic [31:0] rdata;
    } dss_state_t;

    dss_state_t q, n;
    logic syncEdge, tick, prof, ivlOk, push, pop;
    logic [7:0] meas;
    logic [31:0] fbScaled;

    // Master decision shared by both select settings
    function automatic logic masterOn(input logic [1:0] sel, input dss_lock_t lk);
        masterOn = (sel == dss_pkg::SEL_ALWAYS) || (sel == dss_pkg::SEL_LOCKED && lk == DSS_LOCK);
    endfunction

    function automatic logic [31:0] rdMux(input logic [7:0] a, input dss_state_t s);
        rdMux = 32'h0000_0000;
        unique case (a)
            dss_pkg::OFS_ALIAS: rdMux[15:0] = s.zeroAlias;
            dss_pkg::OFS_DSEL: rdMux[1:0] = s.dsel;
            dss_pkg::OFS_MSEL: rdMux[1:0] = s.msel;
            dss_pkg::OFS_CTRL: begin
                rdMux[dss_pkg::CTL_DC] = s.dc;
                rdMux[dss_pkg::CTL_INTERP] = s.interp;
                rdMux[dss_pkg::CTL_SHIFT +: 4] = s.shift;
            end
            dss_pkg::OFS_STAT: begin
                rdMux[dss_pkg::STS_LOCK] = (s.lock == DSS_LOCK);
                rdMux[dss_pkg::STS_LATE] = s.late;
                rdMux[dss_pkg::STS_IVL +: 8] = s.ivl;
                rdMux[dss_pkg::STS_SM +: 4] = dss_pkg::NUM_SM;
                rdMux[dss_pkg::STS_SM_MBX +: 4] = dss_pkg::NUM_SM_MBX;
                rdMux[dss_pkg::STS_SM_PD +: 4] = dss_pkg::NUM_SM_PD;
            end
            default: rdMux = 32'h0000_0000;
        endcase
    endfunction

    // ***********************************
    // Timebase events
    // ***********************************
    // Edge only once the second and third stage agree; sync ignored with clocks off
    assign syncEdge = q.dc && (q.s2 == q.s3) && q.s3 && !q.lvl;
    assign tick = syncEdge || (q.base == TICK_LAST);
    assign prof = q.dc ? syncEdge : tick;
    assign meas = q.since + 8'h01;
    // Off-grid edge or count out of range breaks lock
    assign ivlOk = (q.base == TICK_LAST) && (meas != 8'h00) && (meas <= dss_pkg::MAX_TICKS);
    assign push = q.pend && (q.cnt != dss_pkg::FIFO_DEPTH) && (q.profRem != 16'h0000);
    assign pop = fbReady && (q.cnt != 2'h0);
    assign fbScaled = fbIn >> q.shift;

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        n = q;
        n.s1 = syncIn;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.lvl = q.s3;
        end
        // Edge restarts the base counter so the loop cycle begins at it
        n.base = tick ? 16'h0000 : q.base + 16'h0001;
        if (!q.dc) begin
            n.since = 8'h00;
            n.lock = DSS_ACQ;
        end else if (syncEdge) begin
            n.since = 8'h00;
            n.ivl = meas;
            n.lock = ivlOk ? DSS_LOCK : DSS_ACQ;
        end else if (tick && q.since != 8'hff) begin
            n.since = q.since + 8'h01;
        end
        // Windows open on the cycle after the starting tick
        if (tick) begin
            n.loopRem = WIN_LEN;
        end else if (q.loopRem != 16'h0000) begin
            n.loopRem = q.loopRem - 16'h0001;
        end
        if (prof) begin
            n.profRem = WIN_LEN;
        end else if (q.profRem != 16'h0000) begin
            n.profRem = q.profRem - 16'h0001;
        end
        if (tick) begin
            n.cmd = cmdIn;
            n.fbHold = fbScaled;
        end
        // A push stalled by a full buffer gives up at window end
        if (q.pend && !push && q.profRem == 16'h0001) begin
            n.pend = 1'b0;
            n.late = 1'b1;
        end
        if (push) begin
            n.pend = 1'b0;
            n.mem[q.wp] = q.fbHold;
            n.wp = ~q.wp;
        end
        if (prof) begin
            n.pend = 1'b1;
        end
        if (pop) begin
            n.rp = ~q.rp;
        end
        n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
        // Bus address phase, then write in data phase
        n.aAct = hsel && htrans[1] && hready;
        n.aWr = hwrite;
        n.aAdr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            n.rdata = rdMux(haddr[7:0], q);
        end
        if (q.aAct && q.aWr) begin
            unique case (q.aAdr)
                dss_pkg::OFS_ALIAS: if (hwdata[15:0] <= dss_pkg::ALIAS_MAX) n.zeroAlias = hwdata[15:0];
                dss_pkg::OFS_DSEL: if (hwdata[1:0] <= dss_pkg::SEL_ALWAYS) n.dsel = hwdata[1:0];
                dss_pkg::OFS_MSEL: if (hwdata[1:0] <= dss_pkg::SEL_ALWAYS) n.msel = hwdata[1:0];
                dss_pkg::OFS_CTRL: begin
                    n.dc = hwdata[dss_pkg::CTL_DC];
                    n.interp = hwdata[dss_pkg::CTL_INTERP];
                    n.shift = hwdata[dss_pkg::CTL_SHIFT +: 4];
                end
                // Clear of the late flag loses to a new late event
                dss_pkg::OFS_STAT: if (hwdata[dss_pkg::STS_LATE] && !n.late) n.late = 1'b0;
                default: n.zeroAlias = n.zeroAlias;
            endcase
            if (q.aAdr == dss_pkg::OFS_STAT && hwdata[dss_pkg::STS_LATE] && !(q.pend && !push && q.profRem == 16'h0001)) begin
                n.late = 1'b0;
            end
        end
    end

    // Single register stage for all state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.lock <= DSS_ACQ;
            q.zeroAlias <= dss_pkg::ALIAS_RST;
            q.dsel <= dss_pkg::SEL_RST;
            q.msel <= dss_pkg::SEL_RST;
        end else begin
            q <= n;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign loopStart = tick;
    assign profileStart = prof;
    assign posRun = prof;
    assign interpStep = q.interp && tick && !prof;
    assign posConvert = q.interp && tick;
    assign loopWindow = q.loopRem != 16'h0000;
    assign pdoWindow = q.profRem != 16'h0000;
    assign cmdLatched = q.cmd;
    assign fbValid = q.cnt != 2'h0;
    assign fbData = q.mem[q.rp];
    assign driveSyncMaster = masterOn(q.dsel, q.lock);
    assign moduleSyncMaster = masterOn(q.msel, q.lock);
    assign paramZeroValue = q.zeroAlias;

    // ***********************************
    // Checks
    // ***********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence sProf;
        profileStart;
    endsequence
    sequence sPdoOpen;
        pdoWindow[*2];
    endsequence

    a_prof_at_edge: assert property (syncEdge |-> profileStart && loopStart ##1 q.base == 16'h0000)
        else $error("sync edge without profile start");
    a_prof_nodc: assert property (!q.dc |-> profileStart == loopStart)
        else $error("profile start off tick with sync off");
    a_pos_run: assert property (q.dc && loopStart && !syncEdge |-> !posRun)
        else $error("position run between sync edges");
    a_interp_step: assert property (interpStep |-> loopStart && !profileStart ##1 !interpStep)
        else $error("interpolation step misplaced");
    a_cmd_latch: assert property (loopStart |=> loopWindow && cmdLatched == $past(cmdIn))
        else $error("command not latched at cycle start");
    a_pdo_window: assert property (sProf |=> sPdoOpen)
        else $error("process data window not open");
    a_fb_last: assert property (loopStart |=> q.fbHold == $past(fbScaled))
        else $error("feedback hold not from last loop cycle");
    a_fb_publish: assert property (profileStart && q.cnt == 2'h0 |-> ##[1:3] fbValid)
        else $error("feedback not published");
    a_lock_bad: assert property (syncEdge && !ivlOk |=> !driveSyncMaster || q.dsel == dss_pkg::SEL_ALWAYS)
        else $error("invalid interval kept lock");
    a_mod_master: assert property (q.msel == dss_pkg::SEL_NEVER |-> !moduleSyncMaster)
        else $error("module master despite never setting");
endmodule // dss_sync_scheduler
`default_nettype wire

/* File: inc/dss_pkg.sv */
// Notes on behaviour
// - Sync edges are spaced by a whole number of 250 us ticks, at most 15 ms apart.
// - The position controller runs once per sync interval with sync on, else every 250 us tick.
// - In profile mode with sync on, a profile cycle starts in the loop cycle that begins at the sync edge.
// - With sync off, a profile cycle starts every 250 us tick regardless of the sync input.
// - In interpolation mode each interpolation cycle starts at a sync edge and steps run in later loop cycles.
// - Command values are latched from the object store early in the cycle that uses them.
// - Feedback is scaled and held in its cycle and published early in the next cycle.
// - Feedback published once per profile cycle takes the value of the last loop cycle.
// - Process data moves both ways within the first 90 us of every profile cycle.
// - Drive-parameter process data is written within the first 90 us of every loop cycle.
// - Four sync managers exist, two for mailbox traffic and two for process data.
// - Drive sync select 0 never masters the drive, 1 masters once locked, 2 always masters.
// - Module sync select 0 never masters other modules, 1 once locked, 2 always.
// - A writable alias from 0 to 32767 stands in for drive_parameter_zero.
// - In interpolation mode the master position is converted to a drive command every tick.
package dss_pkg;
    // ***********************************
    // Timing
    // ***********************************
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 250;
    localparam int WIN_US = 90;
    localparam int MAX_IVL_MS = 15;
    // Both products are exact at 125 MHz, so no rounding is needed
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int WIN_CYC = WIN_US * CLK_MHZ;
    localparam logic [7:0] MAX_TICKS = 8'((MAX_IVL_MS * 1000) / TICK_US);
    // ***********************************
    // Register map
    // ***********************************
    localparam logic [7:0] OFS_ALIAS = 8'h00;
    localparam logic [7:0] OFS_DSEL = 8'h04;
    localparam logic [7:0] OFS_MSEL = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam int CTL_DC = 0;
    localparam int CTL_INTERP = 1;
    localparam int CTL_SHIFT = 4;
    localparam int STS_LOCK = 0;
    localparam int STS_LATE = 1;
    localparam int STS_IVL = 8;
    localparam int STS_SM = 16;
    localparam int STS_SM_MBX = 20;
    localparam int STS_SM_PD = 24;
    localparam logic [15:0] ALIAS_RST = 16'h0000;
    localparam logic [15:0] ALIAS_MAX = 16'h7fff;
    localparam logic [1:0] SEL_NEVER = 2'h0;
    localparam logic [1:0] SEL_LOCKED = 2'h1;
    localparam logic [1:0] SEL_ALWAYS = 2'h2;
    localparam logic [1:0] SEL_RST = SEL_LOCKED;
    localparam logic [3:0] NUM_SM = 4'h4;
    localparam logic [3:0] NUM_SM_MBX = 4'h2;
    localparam logic [3:0] NUM_SM_PD = 4'h2;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage
